// ==== rtl/mcsu_pkg.sv ====
package mcsu_pkg;

  // Register offsets inside the peripheral control block
  localparam logic [7:0] TOP_CFG_OFFSET = 8'ha0;
  localparam logic [7:0] LOW_CFG_OFFSET = 8'ha2;
  localparam logic [7:0] RFSH_EN_OFFSET = 8'he4;

  // Field positions in the region registers; bit 6 exists in the low register only; bit 15 of the e4h register is the refresh-enable bit
  localparam int BOUND_MSB = 14;
  localparam int BOUND_LSB = 12;
  localparam int ADDR_OFF_BIT = 7;
  localparam int PSRAM_EN_BIT = 6;
  localparam int RDY_IGN_BIT = 2;
  localparam int WAIT_MSB = 1;
  localparam int WAIT_LSB = 0;
  localparam int RFSH_EN_BIT = 15;

  // Reset and fixed values
  localparam logic [15:0] TOP_CFG_RESET = 16'hf03b;
  localparam logic [15:0] LOW_CFG_RESET = 16'h0000;
  localparam logic [15:0] LOW_FIXED_ONES = 16'h0f38;
  localparam logic [15:0] LOW_RW_MASK = 16'h70c7;
  localparam logic [15:0] TOP_FIXED_ONES = 16'h8038;
  localparam logic [15:0] TOP_RW_MASK = 16'h7087;
  localparam logic [19:0] BOOT_FETCH_ADDR = 20'hffff0;

  // Wait-state timing
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] PCS_WAIT_0 = 4'h0;
  localparam logic [WAIT_W-1:0] PCS_WAIT_1 = 4'h1;
  localparam logic [WAIT_W-1:0] PCS_WAIT_2 = 4'h2;
  localparam logic [WAIT_W-1:0] PCS_WAIT_3 = 4'h3;
  localparam logic [WAIT_W-1:0] PCS_WAIT_4 = 4'h5;
  localparam logic [WAIT_W-1:0] PCS_WAIT_5 = 4'h7;
  localparam logic [WAIT_W-1:0] PCS_WAIT_6 = 4'h9;
  localparam logic [WAIT_W-1:0] PCS_WAIT_7 = 4'hf;

  typedef struct packed {
    logic [19:0] addr;
    logic is_mem;
    logic pcs_hit;
  } mcsu_cyc_t;

  typedef struct packed {
    logic ready_ignore;
    logic [2:0] wait_code;
  } mcsu_pcs_cfg_t;

  typedef enum logic [1:0] {
    WT_IDLE = 2'b00,
    WT_COUNT = 2'b01,
    WT_READY = 2'b10
  } mcsu_wt_state_t;

endpackage : mcsu_pkg

// ==== rtl/mcsu_select_unit.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Peripheral wait code maps 0,1,2,3,5,7,9,15 wait states.
// - Peripheral ready-ignore bit drops external ready; wait count always applies.
// - Low select stays off after reset until its register is written.
// - Only the low register address-drive-off bit has a defined reset, zero.
// - Upper-bound code bits 14..12 set low region top, 64K to 512K.
// - Address-drive-off bit 7 set stops address drive for that region.
// - Address-enable strap low at reset release forces address drive always.
// - Pseudo-static enable bit 6 marks low region accesses as pseudo-static.
// - Refresh-enable bit at e4h turns midrange select 3 into refresh strobe.
// - Low region ready-ignore bit 2 drops ready; wait field still applies.
// - Low region wait field inserts its binary value, zero to three.
// - Top select active after reset: 64K at F0000h, ready, three waits.
// - Top region always ends at FFFFFh; lower end programmable.
// - Top register holds F03Bh after reset.
// - First fetch at FFFF0h lands inside the reset top region.
// - Top region lower boundary gives sizes 64K to 512K.
// - Any active select with drive-off set suppresses address, even overlapped, unless the strap forced drive.
module mcsu_select_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pcb_addr,
  input wire logic pcb_wr,
  input wire logic pcb_rd,
  input wire logic [15:0] pcb_wdata,
  output logic [15:0] pcb_rdata,
  input wire logic cyc_start,
  input wire mcsu_pkg::mcsu_cyc_t cyc_req,
  input wire mcsu_pkg::mcsu_pcs_cfg_t pcs_cfg,
  input wire logic ext_ready,
  input wire logic aden_n,
  output logic low_sel_n,
  output logic top_sel_n,
  output logic addr_drive_en,
  output logic psram_access,
  output logic midrange_select_3_refresh,
  output logic cyc_busy,
  output logic cyc_done
);

  logic [15:0] top_cfg_reg;
  logic [15:0] low_cfg_reg;
  logic low_enabled_reg;
  logic rfsh_en_reg;
  logic force_addr_reg;
  logic low_sel_reg;
  logic top_sel_reg;
  logic addr_drive_reg;
  logic psram_reg;
  logic [15:0] rdata_reg;

  logic low_hit;
  logic top_hit;
  logic [2:0] low_code;
  logic [2:0] top_code;
  logic [mcsu_pkg::WAIT_W-1:0] pcs_wait;
  logic [mcsu_pkg::WAIT_W-1:0] low_wait;
  logic [mcsu_pkg::WAIT_W-1:0] top_wait;
  logic [mcsu_pkg::WAIT_W-1:0] wait_next;
  logic ready_req_next;
  logic drive_next;
  logic timer_busy;
  logic timer_done;

  // Peripheral select wait encoding
  function automatic logic [mcsu_pkg::WAIT_W-1:0] pcs_wait_decode(input logic [2:0] code);
    logic [mcsu_pkg::WAIT_W-1:0] w;
    w = mcsu_pkg::PCS_WAIT_0;
    unique case (code)
      3'h0: w = mcsu_pkg::PCS_WAIT_0;
      3'h1: w = mcsu_pkg::PCS_WAIT_1;
      3'h2: w = mcsu_pkg::PCS_WAIT_2;
      3'h3: w = mcsu_pkg::PCS_WAIT_3;
      3'h4: w = mcsu_pkg::PCS_WAIT_4;
      3'h5: w = mcsu_pkg::PCS_WAIT_5;
      3'h6: w = mcsu_pkg::PCS_WAIT_6;
      3'h7: w = mcsu_pkg::PCS_WAIT_7;
    endcase
    return w;
  endfunction : pcs_wait_decode

  // Register writes over the control block port
  always_ff @(posedge mclk) begin
    if (rst) begin
      top_cfg_reg <= mcsu_pkg::TOP_CFG_RESET;
    end else if (pcb_wr && pcb_addr == mcsu_pkg::TOP_CFG_OFFSET) begin
      top_cfg_reg <= (pcb_wdata & mcsu_pkg::TOP_RW_MASK) | mcsu_pkg::TOP_FIXED_ONES;
    end
  end

  // Other fields are formally undefined; zero keeps simulation clean
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_cfg_reg <= mcsu_pkg::LOW_CFG_RESET | mcsu_pkg::LOW_FIXED_ONES;
    end else if (pcb_wr && pcb_addr == mcsu_pkg::LOW_CFG_OFFSET) begin
      low_cfg_reg <= (pcb_wdata & mcsu_pkg::LOW_RW_MASK) | mcsu_pkg::LOW_FIXED_ONES;
    end
  end

  // Any write to the low register arms the low select
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_enabled_reg <= 1'b0;
    end else if (pcb_wr && pcb_addr == mcsu_pkg::LOW_CFG_OFFSET) begin
      low_enabled_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rfsh_en_reg <= 1'b0;
    end else if (pcb_wr && pcb_addr == mcsu_pkg::RFSH_EN_OFFSET) begin
      rfsh_en_reg <= pcb_wdata[mcsu_pkg::RFSH_EN_BIT];
    end
  end

  assign midrange_select_3_refresh = rfsh_en_reg;

  // Strap tracked while reset is held, so the last value before release sticks
  always_ff @(posedge mclk) begin
    if (rst) begin
      force_addr_reg <= ~aden_n;
    end
  end

  // Reads are registered; unmapped offsets return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (pcb_rd) begin
      unique case (pcb_addr)
        mcsu_pkg::TOP_CFG_OFFSET: rdata_reg <= top_cfg_reg;
        mcsu_pkg::LOW_CFG_OFFSET: rdata_reg <= low_cfg_reg;
        mcsu_pkg::RFSH_EN_OFFSET: rdata_reg <= {rfsh_en_reg, 15'h0000};
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign pcb_rdata = rdata_reg;

  // Address decode
  assign low_code = low_cfg_reg[mcsu_pkg::BOUND_MSB:mcsu_pkg::BOUND_LSB];
  assign top_code = top_cfg_reg[mcsu_pkg::BOUND_MSB:mcsu_pkg::BOUND_LSB];

  // Bits above the block size must be zero below the low region top
  assign low_hit = cyc_req.is_mem && low_enabled_reg && !cyc_req.addr[19]
                   && ((cyc_req.addr[18:16] & ~low_code) == 3'h0);

  // Upper end is fixed at FFFFFh, so only the bits the code keeps are compared
  assign top_hit = cyc_req.is_mem && cyc_req.addr[19]
                   && ((cyc_req.addr[18:16] | ~top_code) == 3'h7);

  assign pcs_wait = pcs_wait_decode(pcs_cfg.wait_code);
  assign low_wait = {2'b00, low_cfg_reg[mcsu_pkg::WAIT_MSB:mcsu_pkg::WAIT_LSB]};
  assign top_wait = {2'b00, top_cfg_reg[mcsu_pkg::WAIT_MSB:mcsu_pkg::WAIT_LSB]};

  // Overlaps should agree in setup; top wins, then low, then peripheral
  always_comb begin
    wait_next = '0;
    ready_req_next = 1'b0;
    if (top_hit) begin
      wait_next = top_wait;
      ready_req_next = ~top_cfg_reg[mcsu_pkg::RDY_IGN_BIT];
    end else if (low_hit) begin
      wait_next = low_wait;
      ready_req_next = ~low_cfg_reg[mcsu_pkg::RDY_IGN_BIT];
    end else if (cyc_req.pcs_hit) begin
      wait_next = pcs_wait;
      ready_req_next = ~pcs_cfg.ready_ignore;
    end
  end

  // Either active region with drive-off wins, even when another select overlaps, unless the reset strap forces drive
  assign drive_next = force_addr_reg
                      || !((low_hit && low_cfg_reg[mcsu_pkg::ADDR_OFF_BIT])
                           || (top_hit && top_cfg_reg[mcsu_pkg::ADDR_OFF_BIT]));

  mcsu_wait_timer #(
    .WIDTH(mcsu_pkg::WAIT_W)
  ) u_wait_timer (
    .mclk(mclk),
    .rst(rst),
    .start(cyc_start && !timer_busy),
    .wait_count(wait_next),
    .ready_req(ready_req_next),
    .ext_ready(ext_ready),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Selects and drive control held for the whole cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_sel_reg <= 1'b0;
      top_sel_reg <= 1'b0;
      addr_drive_reg <= 1'b1;
      psram_reg <= 1'b0;
    end else if (cyc_start && !timer_busy) begin
      low_sel_reg <= low_hit;
      top_sel_reg <= top_hit;
      addr_drive_reg <= drive_next;
      psram_reg <= low_hit && low_cfg_reg[mcsu_pkg::PSRAM_EN_BIT];
    end else if (timer_done) begin
      low_sel_reg <= 1'b0;
      top_sel_reg <= 1'b0;
      addr_drive_reg <= 1'b1;
      psram_reg <= 1'b0;
    end
  end

  assign low_sel_n = ~low_sel_reg;
  assign top_sel_n = ~top_sel_reg;
  assign addr_drive_en = addr_drive_reg;
  assign psram_access = psram_reg;
  assign cyc_busy = timer_busy;
  assign cyc_done = timer_done;

endmodule : mcsu_select_unit

`default_nettype wire

// ==== rtl/mcsu_wait_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module mcsu_wait_timer #(
  parameter int WIDTH = mcsu_pkg::WAIT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [WIDTH-1:0] wait_count,
  input wire logic ready_req,
  input wire logic ext_ready,
  output logic busy,
  output logic done
);

  mcsu_pkg::mcsu_wt_state_t state_reg;
  logic [WIDTH-1:0] count_reg;
  logic ready_req_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= mcsu_pkg::WT_IDLE;
      count_reg <= '0;
      ready_req_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        mcsu_pkg::WT_IDLE: begin
          if (start) begin
            count_reg <= wait_count;
            ready_req_reg <= ready_req;
            state_reg <= mcsu_pkg::WT_COUNT;
          end
        end
        mcsu_pkg::WT_COUNT: begin
          if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
          end else if (ready_req_reg && !ext_ready) begin
            state_reg <= mcsu_pkg::WT_READY;
          end else begin
            state_reg <= mcsu_pkg::WT_IDLE;
          end
        end
        mcsu_pkg::WT_READY: begin
          // Ready is only looked at once all wait states have run
          if (ext_ready) begin
            state_reg <= mcsu_pkg::WT_IDLE;
          end
        end
        default: begin
          state_reg <= mcsu_pkg::WT_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_reg != mcsu_pkg::WT_IDLE);
  assign done = ((state_reg == mcsu_pkg::WT_COUNT) && (count_reg == '0)
                 && (!ready_req_reg || ext_ready))
                || ((state_reg == mcsu_pkg::WT_READY) && ext_ready);

endmodule : mcsu_wait_timer

`default_nettype wire

// ==== verification/mcsu_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsu_mem_model (
  input wire logic mclk,
  input wire logic cyc_busy,
  input wire logic [3:0] stall,
  output logic ext_ready
);
  logic [3:0] cnt_reg = 4'h0;
  logic flip_reg = 1'b0;
  always_ff @(posedge mclk) begin
    cnt_reg <= cyc_busy ? cnt_reg + 4'h1 : 4'h0;
    flip_reg <= ~flip_reg;
  end
  // Wanders outside a cycle so a stale ready never passes
  assign ext_ready = cyc_busy ? (cnt_reg >= stall) : flip_reg;
endmodule : mcsu_mem_model
`default_nettype wire

// ==== verification/mcsu_select_unit_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcsu_select_unit_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pcb_addr,
  input wire logic pcb_wr,
  input wire logic cyc_start,
  input wire logic ext_ready,
  input wire logic aden_n,
  input wire logic low_sel_n,
  input wire logic top_sel_n,
  input wire logic addr_drive_en,
  input wire logic psram_access,
  input wire logic cyc_busy,
  input wire logic cyc_done
);
  logic armed_reg;
  logic boot_reg;
  logic strap_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      armed_reg <= 1'b0;
      boot_reg <= 1'b1;
      strap_reg <= aden_n;
    end else if (pcb_wr) begin
      armed_reg <= armed_reg | (pcb_addr == mcsu_pkg::LOW_CFG_OFFSET);
      boot_reg <= boot_reg & (pcb_addr != mcsu_pkg::TOP_CFG_OFFSET);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_start_busy: assert property (cyc_start && !cyc_busy |=> cyc_busy)
    else $error("start not taken");
  a_done_release: assert property (cyc_done |-> cyc_busy ##1
    (!cyc_busy && !cyc_done && low_sel_n && top_sel_n)) else $error("bad cycle end");
  a_sel_held: assert property (cyc_busy && $past(cyc_busy) |->
    $stable({low_sel_n, top_sel_n, addr_drive_en, psram_access})) else $error("select moved");
  a_idle_quiet: assert property (!cyc_busy |->
    low_sel_n && top_sel_n && addr_drive_en && !psram_access) else $error("idle not quiet");
  a_low_unarmed: assert property (!armed_reg |-> low_sel_n)
    else $error("low select before write");
  a_boot_waits: assert property ($rose(cyc_busy) && !top_sel_n && boot_reg |->
    !cyc_done [*3] ##1 (cyc_done == ext_ready)) else $error("boot wait wrong");
  a_strap_drive: assert property (!strap_reg |-> addr_drive_en)
    else $error("strap ignored");
  a_psram_low: assert property (psram_access |-> !low_sel_n)
    else $error("psram outside low");
  c_top: cover property (cyc_done && !top_sel_n);
  c_low: cover property (cyc_done && !low_sel_n && psram_access);
  c_refused: cover property (cyc_start && cyc_busy);
endmodule : mcsu_select_unit_asserts
`default_nettype wire

// ==== verification/tb_memory_chip_select_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_memory_chip_select_unit;
  localparam logic [3:0] PCS_TBL [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hf};
  localparam logic [2:0] BND [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam logic [2:0] TBC [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pcb_addr = 8'h00;
  logic pcb_wr = 1'b0;
  logic pcb_rd = 1'b0;
  logic [15:0] pcb_wdata = 16'h0000;
  logic cyc_start = 1'b0;
  mcsu_pkg::mcsu_cyc_t cyc_req = '0;
  mcsu_pkg::mcsu_pcs_cfg_t pcs_cfg = '0;
  logic aden_n = 1'b1;
  logic [3:0] stall = 4'h0;
  logic [31:0] seed = 32'hd71d;
  logic [15:0] pcb_rdata;
  logic ext_ready, low_sel_n, top_sel_n, addr_drive_en, psram_access;
  logic midrange_select_3_refresh, cyc_busy, cyc_done;
  int failures = 0;
  int tests_run = 0;
  always #50 mclk = ~mclk;
  mcsu_select_unit uut (.mclk(mclk), .rst(rst), .pcb_addr(pcb_addr), .pcb_wr(pcb_wr),
    .pcb_rd(pcb_rd), .pcb_wdata(pcb_wdata), .pcb_rdata(pcb_rdata), .cyc_start(cyc_start),
    .cyc_req(cyc_req), .pcs_cfg(pcs_cfg), .ext_ready(ext_ready), .aden_n(aden_n),
    .low_sel_n(low_sel_n), .top_sel_n(top_sel_n), .addr_drive_en(addr_drive_en),
    .psram_access(psram_access), .midrange_select_3_refresh(midrange_select_3_refresh),
    .cyc_busy(cyc_busy), .cyc_done(cyc_done));
  mcsu_mem_model mem (.mclk(mclk), .cyc_busy(cyc_busy), .stall(stall), .ext_ready(ext_ready));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int lat(input int w, input logic ign);
    return 1 + ((ign || w >= stall) ? w : stall);
  endfunction : lat
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    pcb_addr <= a;
    pcb_wdata <= d;
    pcb_wr <= 1'b1;
    @(posedge mclk);
    pcb_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    pcb_addr <= a;
    pcb_rd <= 1'b1;
    @(posedge mclk);
    pcb_rd <= 1'b0;
    @(negedge mclk);
    d = pcb_rdata;
  endtask : reg_rd
  task automatic run_cyc(input logic [19:0] a, input logic m, input logic p, output int n,
      output logic [3:0] s);
    logic dn;
    @(posedge mclk);
    cyc_req <= '{addr: a, is_mem: m, pcs_hit: p};
    cyc_start <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    s = {low_sel_n, top_sel_n, addr_drive_en, psram_access};
    dn = cyc_done;
    n = 1;
    // Start left up one more edge: busy sequencer must refuse it
    @(posedge mclk);
    cyc_start <= 1'b0;
    while (dn !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
      dn = cyc_done;
    end
    // Return past the edge that ends the cycle, so stall changes never race ready
    @(negedge mclk);
  endtask : run_cyc
  task automatic conclude();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    logic [15:0] d;
    logic [15:0] v;
    logic [19:0] t;
    logic [3:0] s;
    int n;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    reg_rd(mcsu_pkg::TOP_CFG_OFFSET, d);
    `CHK("top reset", 16'hf03b, d)
    reg_rd(mcsu_pkg::LOW_CFG_OFFSET, d);
    `CHK("low drive-off reset", 1'b0, d[7])
    reg_rd(8'h10, d);
    `CHK("unmapped", 16'h0000, d)
    stall = 4'h5;
    run_cyc(mcsu_pkg::BOOT_FETCH_ADDR, 1'b1, 1'b0, n, s);
    `CHK("boot sel", 4'b1010, s)
    `CHK("boot lat", lat(3, 1'b0), n)
    run_cyc(20'h00100, 1'b1, 1'b0, n, s);
    `CHK("low unarmed", 1'b1, s[3])
    reg_wr(mcsu_pkg::RFSH_EN_OFFSET, 16'h8000);
    @(negedge mclk);
    `CHK("refresh on", 1'b1, midrange_select_3_refresh)
    foreach (BND[i]) begin
      seed = lfsr(seed);
      v = {1'b0, BND[i], 4'h0, seed[7:6], 3'h0, seed[2:0]};
      stall = seed[11:8] & 4'h7;
      reg_wr(mcsu_pkg::LOW_CFG_OFFSET, v);
      reg_rd(mcsu_pkg::LOW_CFG_OFFSET, d);
      `CHK("low cfg", v | 16'h0f38, d)
      t = {1'b0, BND[i], 16'hffff};
      run_cyc(t, 1'b1, seed[3], n, s);
      `CHK("low sel", {2'b01, ~v[7], v[6]}, s)
      `CHK("low lat", lat(v[1:0], v[2]), n)
      run_cyc(t + 20'h1, 1'b1, 1'b0, n, s);
      `CHK("low miss", 1'b1, s[3])
    end
    foreach (TBC[i]) begin
      seed = lfsr(seed);
      v = {1'b1, TBC[i], 4'h0, seed[7], 1'b0, 3'h7, seed[2:0]};
      stall = seed[11:8] & 4'h7;
      reg_wr(mcsu_pkg::TOP_CFG_OFFSET, v);
      reg_rd(mcsu_pkg::TOP_CFG_OFFSET, d);
      `CHK("top cfg", v, d)
      t = {1'b1, TBC[i], 16'h0000};
      run_cyc(t, 1'b1, 1'b0, n, s);
      `CHK("top sel", {2'b10, ~v[7], 1'b0}, s)
      `CHK("top lat", lat(v[1:0], v[2]), n)
      run_cyc(t - 20'h1, 1'b1, 1'b0, n, s);
      `CHK("top below", 1'b1, s[2])
      run_cyc(20'hfffff, 1'b1, 1'b0, n, s);
      `CHK("top end", 1'b0, s[2])
    end
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      stall = seed[11:8];
      @(posedge mclk);
      pcs_cfg <= '{ready_ignore: seed[0], wait_code: 3'(k)};
      run_cyc(20'h00300, 1'b0, 1'b1, n, s);
      `CHK("pcs lat", lat(PCS_TBL[k], seed[0]), n)
    end
    reg_wr(mcsu_pkg::RFSH_EN_OFFSET, 16'h0000);
    reg_rd(mcsu_pkg::RFSH_EN_OFFSET, d);
    `CHK("refresh off", 16'h0000, d)
    @(posedge mclk);
    rst <= 1'b1;
    aden_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    aden_n <= 1'b1;
    reg_wr(mcsu_pkg::LOW_CFG_OFFSET, 16'h7080);
    run_cyc(20'h00000, 1'b1, 1'b0, n, s);
    `CHK("strap drive", 4'b0110, s)
    conclude();
  end
endmodule : tb_memory_chip_select_unit
bind mcsu_select_unit mcsu_select_unit_asserts chk (.mclk(mclk), .rst(rst),
  .pcb_addr(pcb_addr), .pcb_wr(pcb_wr), .cyc_start(cyc_start), .ext_ready(ext_ready),
  .aden_n(aden_n), .low_sel_n(low_sel_n), .top_sel_n(top_sel_n),
  .addr_drive_en(addr_drive_en), .psram_access(psram_access), .cyc_busy(cyc_busy),
  .cyc_done(cyc_done));
`default_nettype wire
